/* src/sec_ctrl.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-wire slave reads, control byte access, protection and watchdog.
// Assumes: Pins are asynchronous and pass two flip-flops before use.
// Notes:   Array writes land at once; no programming busy time is modelled.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module sec_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         flush_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out && !flush_in;
  assign pop           = out_valid_out && out_ready_in && !flush_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      if (pop) rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      count_r <= (AW+1)'(count_r + push - pop);
    end
  end
endmodule : sec_fifo

module sec_ctrl #(
  parameter int unsigned WD_LONG_CYC  = int'(sec_pkg::WD_LONG_CYC),
  parameter int unsigned WD_MID_CYC   = int'(sec_pkg::WD_MID_CYC),
  parameter int unsigned WD_SHORT_CYC = int'(sec_pkg::WD_SHORT_CYC)
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic [1:0] dev_sel_in,
  input  wire logic       wp_pin_in,
  input  wire logic       on_battery_in,
  output logic            wdog_timeout_n_out,
  output logic            powerup_reset_time_sel_out
);
  localparam int AW = sec_pkg::ADDR_W;

  sec_pkg::sec_state_e state_r;
  logic [5:0]    meta_r;
  logic [5:0]    sync_r;
  logic [1:0]    prev_r;
  logic [3:0]    bitcnt_r;
  logic [7:0]    shift_r;
  logic [7:0]    tx_r;
  logic          sda_oe_n_r;
  logic          sda_out_r;
  logic          rw_r;
  logic          ackd_r;
  logic          cr_rd_r;
  logic          cr_got_r;
  logic [7:0]    addr_hi_r;
  logic [AW-1:0] addr_cnt_r;
  logic          cr_sel_r;
  logic [7:0]    cr_r;
  logic          nv_pend_r;
  logic [7:0]    nv_val_r;
  logic [7:0]    mem_r [0:(1<<AW)-1];
  logic [AW-1:0] pf_addr_r;
  logic          flush_d_r;
  logic          armed_r;
  logic [31:0]   wd_cnt_r;
  logic          wdo_n_r;
  logic          pup_r;

  logic scl, sda, scl_rise, scl_fall, start_det, stop_det, wp_s, batt_s;
  logic byte_done, rx_state, dev_match, rom, prot, ack_now, tx_load, restart;
  logic cr_wr, cr_clr, cr_setwel, cr_setrwel, cr_nv, cr_keep, arr_wr, addr_load;
  logic flush_now, fifo_in_ready, fifo_out_valid, wd_off;
  logic [7:0]    fifo_out_data;
  logic [7:0]    tx_byte;
  logic [15:0]   addr_word;
  logic [AW-1:0] addr_word_low;
  logic [31:0]   wd_limit;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= 6'h03;
      sync_r <= 6'h03;
      prev_r <= 2'h3;
    end else begin
      meta_r <= {on_battery_in, wp_pin_in, dev_sel_in, sda_in, scl_in};
      sync_r <= meta_r;
      prev_r <= sync_r[1:0];
    end
  end

  assign scl       = sync_r[0];
  assign sda       = sync_r[1];
  assign wp_s      = sync_r[4];
  assign batt_s    = sync_r[5];
  assign scl_rise  = scl && !prev_r[0];
  assign scl_fall  = !scl && prev_r[0];
  assign start_det = scl && prev_r[0] && prev_r[1] && !sda;
  assign stop_det  = scl && prev_r[0] && !prev_r[1] && sda;

  //////////////////////////////////////////////////////////////////////////////
  // Byte decisions.
  assign rx_state  = (state_r == sec_pkg::ST_DEVADDR) || (state_r == sec_pkg::ST_ADDR1) ||
                     (state_r == sec_pkg::ST_ADDR0) || (state_r == sec_pkg::ST_WDATA);
  assign byte_done = rx_state && scl_fall && (bitcnt_r == 4'h8);
  assign dev_match = (shift_r[7:1] == {sec_pkg::DEV_TYPE, 1'b0, sync_r[3:2]});
  assign rom       = wp_s && cr_r[sec_pkg::CR_HW_PROTECT_ENABLE_BIT];
  assign addr_word = {addr_hi_r, shift_r};
  assign addr_word_low = addr_word[AW-1:0];

  always_comb begin
    case (cr_r[sec_pkg::CR_BP1:sec_pkg::CR_BP0])
      sec_pkg::BP_NONE:    prot = 1'b0;
      sec_pkg::BP_QUARTER: prot = (addr_cnt_r >= sec_pkg::BP_Q_BASE);
      sec_pkg::BP_HALF:    prot = (addr_cnt_r >= sec_pkg::BP_H_BASE);
      default:             prot = 1'b1;
    endcase
  end

  assign cr_wr      = byte_done && (state_r == sec_pkg::ST_WDATA) && cr_sel_r && !cr_got_r;
  assign cr_clr     = (shift_r == sec_pkg::CR_CLR_WEL);
  assign cr_setwel  = (shift_r == sec_pkg::CR_SET_WEL);
  assign cr_setrwel = (shift_r == sec_pkg::CR_SET_REGISTER_WRITE_LATCH) && cr_r[sec_pkg::CR_WEL];
  assign cr_keep    = cr_r[sec_pkg::CR_WEL] && cr_r[sec_pkg::CR_REGISTER_WRITE_LATCH] && shift_r[sec_pkg::CR_REGISTER_WRITE_LATCH];
  assign cr_nv      = cr_r[sec_pkg::CR_WEL] && cr_r[sec_pkg::CR_REGISTER_WRITE_LATCH] && !shift_r[sec_pkg::CR_REGISTER_WRITE_LATCH] &&
                      shift_r[sec_pkg::CR_WEL];
  assign arr_wr     = byte_done && (state_r == sec_pkg::ST_WDATA) && !cr_sel_r &&
                      cr_r[sec_pkg::CR_WEL];
  assign addr_load  = byte_done && (state_r == sec_pkg::ST_ADDR0);

  always_comb begin
    case (state_r)
      sec_pkg::ST_DEVADDR: ack_now = dev_match;
      sec_pkg::ST_ADDR1:   ack_now = 1'b1;
      sec_pkg::ST_ADDR0:   ack_now = 1'b1;
      sec_pkg::ST_WDATA:   ack_now = cr_sel_r ? (!cr_got_r && !cr_clr &&
                                                 (cr_setwel || cr_setrwel || cr_keep || cr_nv))
                                              : cr_r[sec_pkg::CR_WEL];
      default:             ack_now = 1'b0;
    endcase
  end

  assign tx_load = scl_fall && (((state_r == sec_pkg::ST_DEV_ACK) && rw_r) ||
                   ((state_r == sec_pkg::ST_RDATA_ACK) && ackd_r && !cr_rd_r));
  assign tx_byte = cr_sel_r ? cr_r : (fifo_out_valid ? fifo_out_data : 8'hff);

  //////////////////////////////////////////////////////////////////////////////
  // Bus state machine, shifter and open-drain drive.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r    <= sec_pkg::ST_IDLE;
      bitcnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      sda_oe_n_r <= 1'b1;
      rw_r       <= 1'b0;
      ackd_r     <= 1'b0;
      cr_rd_r    <= 1'b0;
      cr_got_r   <= 1'b0;
    end else if (start_det) begin
      state_r    <= sec_pkg::ST_DEVADDR;
      bitcnt_r   <= 4'h0;
      sda_oe_n_r <= 1'b1;
      cr_rd_r    <= 1'b0;
      cr_got_r   <= 1'b0;
    end else if (stop_det) begin
      state_r    <= sec_pkg::ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      if (rx_state && scl_rise && (bitcnt_r != 4'h8)) begin
        shift_r  <= {shift_r[6:0], sda};
        bitcnt_r <= bitcnt_r + 4'h1;
      end
      if (byte_done) begin
        bitcnt_r <= 4'h0;
        if (state_r == sec_pkg::ST_DEVADDR) rw_r <= shift_r[0];
        if (state_r == sec_pkg::ST_WDATA && cr_sel_r) cr_got_r <= 1'b1;
        sda_oe_n_r <= !ack_now;
        case (state_r)
          sec_pkg::ST_DEVADDR: state_r <= ack_now ? sec_pkg::ST_DEV_ACK : sec_pkg::ST_IDLE;
          sec_pkg::ST_ADDR1:   state_r <= sec_pkg::ST_ADDR1_ACK;
          sec_pkg::ST_ADDR0:   state_r <= sec_pkg::ST_ADDR0_ACK;
          default:             state_r <= ack_now ? sec_pkg::ST_WDATA_ACK : sec_pkg::ST_IDLE;
        endcase
      end else if (scl_fall) begin
        case (state_r)
          sec_pkg::ST_DEV_ACK: begin
            state_r    <= rw_r ? sec_pkg::ST_RDATA : sec_pkg::ST_ADDR1;
            tx_r       <= {tx_byte[6:0], 1'b0};
            sda_oe_n_r <= rw_r ? tx_byte[7] : 1'b1;
            cr_rd_r    <= rw_r && cr_sel_r;
          end
          sec_pkg::ST_ADDR1_ACK: begin
            state_r    <= sec_pkg::ST_ADDR1_ACK == state_r ? sec_pkg::ST_ADDR0 : state_r;
            sda_oe_n_r <= 1'b1;
          end
          sec_pkg::ST_ADDR0_ACK, sec_pkg::ST_WDATA_ACK: begin
            state_r    <= sec_pkg::ST_WDATA;
            sda_oe_n_r <= 1'b1;
          end
          sec_pkg::ST_RDATA: begin
            if (bitcnt_r == 4'h7) begin
              state_r    <= sec_pkg::ST_RDATA_ACK;
              bitcnt_r   <= 4'h0;
              sda_oe_n_r <= 1'b1;
            end else begin
              bitcnt_r   <= bitcnt_r + 4'h1;
              tx_r       <= {tx_r[6:0], 1'b0};
              sda_oe_n_r <= tx_r[7];
            end
          end
          sec_pkg::ST_RDATA_ACK: begin
            if (ackd_r && !cr_rd_r) begin
              state_r    <= sec_pkg::ST_RDATA;
              tx_r       <= {tx_byte[6:0], 1'b0};
              sda_oe_n_r <= tx_byte[7];
            end else begin
              state_r    <= sec_pkg::ST_IDLE;
            end
          end
          default: ;
        endcase
      end
      if (state_r == sec_pkg::ST_RDATA_ACK && scl_rise) ackd_r <= !sda;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address counter.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_hi_r  <= 8'h00;
      addr_cnt_r <= '0;
      cr_sel_r   <= 1'b0;
    end else begin
      if (byte_done && state_r == sec_pkg::ST_ADDR1) addr_hi_r <= shift_r;
      if (addr_load) begin
        addr_cnt_r <= addr_word_low;
        cr_sel_r   <= (addr_word == sec_pkg::CR_WORD_ADDR);
      end else if (tx_load && !cr_sel_r) begin
        addr_cnt_r <= AW'(addr_cnt_r + 1'b1);
      end else if (arr_wr) begin
        addr_cnt_r[sec_pkg::PAGE_W-1:0] <= sec_pkg::PAGE_W'(addr_cnt_r[sec_pkg::PAGE_W-1:0] + 1'b1);
      end else if (scl_fall && state_r == sec_pkg::ST_RDATA_ACK && cr_rd_r) begin
        addr_cnt_r <= '0;
        cr_sel_r   <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control byte: volatile latches at once, nonvolatile bits at the stop.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cr_r      <= sec_pkg::CR_RESET;
      nv_pend_r <= 1'b0;
      nv_val_r  <= 8'h00;
    end else begin
      if (cr_wr) begin
        if (cr_clr) cr_r[sec_pkg::CR_WEL] <= 1'b0;
        if (cr_setwel) cr_r[sec_pkg::CR_WEL] <= 1'b1;
        if (cr_setrwel) cr_r[sec_pkg::CR_REGISTER_WRITE_LATCH] <= 1'b1;
        if (cr_nv) begin
          nv_pend_r <= 1'b1;
          nv_val_r  <= shift_r;
        end
      end
      if (arr_wr && prot) cr_r[sec_pkg::CR_REGISTER_WRITE_LATCH] <= 1'b0;
      if (start_det) nv_pend_r <= 1'b0;
      if (stop_det && nv_pend_r) begin
        nv_pend_r <= 1'b0;
        cr_r[sec_pkg::CR_REGISTER_WRITE_LATCH] <= 1'b0;
        if (!rom) begin
          cr_r[sec_pkg::CR_HW_PROTECT_ENABLE_BIT:sec_pkg::CR_BP0] <= nv_val_r[sec_pkg::CR_HW_PROTECT_ENABLE_BIT:sec_pkg::CR_BP0];
          cr_r[sec_pkg::CR_PUP] <= nv_val_r[sec_pkg::CR_PUP];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array storage and read prefetch into the FIFO.
  always_ff @(posedge sys_clk_in) begin
    if (arr_wr && !prot) mem_r[addr_cnt_r] <= shift_r;
  end

  assign flush_now = start_det || stop_det || addr_load || arr_wr;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flush_d_r <= 1'b0;
      pf_addr_r <= '0;
    end else begin
      flush_d_r <= flush_now;
      if (flush_d_r) pf_addr_r <= addr_cnt_r;
      else if (!flush_now && !cr_sel_r && fifo_in_ready) pf_addr_r <= AW'(pf_addr_r + 1'b1);
    end
  end

  sec_fifo #(.W(8), .DEPTH(sec_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in        (sys_clk_in),
    .rstn_in       (rstn_in),
    .flush_in      (flush_now || flush_d_r),
    .in_valid_in   (!cr_sel_r),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mem_r[pf_addr_r]),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (tx_load && !cr_sel_r),
    .out_data_out  (fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog.
  assign wd_off  = (cr_r[sec_pkg::CR_WD1:sec_pkg::CR_WD0] == 2'h3);
  assign restart = armed_r && scl_fall;

  always_comb begin
    case (cr_r[sec_pkg::CR_WD1:sec_pkg::CR_WD0])
      sec_pkg::WD_LONG:  wd_limit = WD_LONG_CYC;
      sec_pkg::WD_MID:   wd_limit = WD_MID_CYC;
      sec_pkg::WD_SHORT: wd_limit = WD_SHORT_CYC;
      default:           wd_limit = 32'hffffffff;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed_r  <= 1'b0;
      wd_cnt_r <= 32'h0;
      wdo_n_r  <= 1'b1;
    end else begin
      if (start_det) armed_r <= 1'b1;
      else if (restart) armed_r <= 1'b0;
      if (restart || wd_off) begin
        wd_cnt_r <= 32'h0;
        wdo_n_r  <= 1'b1;
      end else if (!batt_s) begin
        if (wd_cnt_r >= wd_limit - 32'h1) wdo_n_r <= 1'b0;
        else wd_cnt_r <= wd_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out_r <= 1'b0;
      pup_r     <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
      pup_r     <= cr_r[sec_pkg::CR_PUP];
    end
  end

  assign sda_out                    = sda_out_r;
  assign sda_oe_n_out               = sda_oe_n_r;
  assign wdog_timeout_n_out         = wdo_n_r;
  assign powerup_reset_time_sel_out = pup_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_addr_set_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    addr_load |=> addr_cnt_r == $past(addr_word_low)) else $error("address not loaded");
  a_seq_next_byte: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state_r == sec_pkg::ST_RDATA_ACK && scl_fall && ackd_r && !cr_rd_r && !stop_det && !start_det)
    |=> state_r == sec_pkg::ST_RDATA) else $error("no next byte after ack");
  a_counter_wrap: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (tx_load && !cr_sel_r && !addr_load && addr_cnt_r == '1) |=> addr_cnt_r == '0)
    else $error("counter did not wrap");
  a_cr_extra_nack: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (byte_done && state_r == sec_pkg::ST_WDATA && cr_sel_r && cr_got_r && !start_det && !stop_det)
    |=> sda_oe_n_r && state_r == sec_pkg::ST_IDLE) else $error("extra control byte acked");
  a_cr_read_single: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state_r == sec_pkg::ST_RDATA_ACK && scl_fall && cr_rd_r && !start_det && !stop_det)
    |=> state_r == sec_pkg::ST_IDLE ##0 addr_cnt_r == '0) else $error("control read not single");
  a_wel_gate_nack: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (byte_done && state_r == sec_pkg::ST_WDATA && !cr_sel_r && !cr_r[sec_pkg::CR_WEL]
     && !start_det && !stop_det) |=> sda_oe_n_r [*2]) else $error("write acked with latch clear");
  a_rom_nv_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (stop_det && nv_pend_r && rom) |=> $stable(cr_r[sec_pkg::CR_HW_PROTECT_ENABLE_BIT:sec_pkg::CR_BP0]))
    else $error("nonvolatile bits changed in rom mode");
  a_wdog_restart: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    restart |=> wd_cnt_r == 32'h0 && wdo_n_r) else $error("watchdog not restarted");
  a_wdog_battery: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (batt_s && !restart && !wd_off) |=> $stable(wd_cnt_r)) else $error("watchdog ran on battery");
  a_wdog_off_idle: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    wd_off |=> wdo_n_r && wd_cnt_r == 32'h0) else $error("disabled watchdog fired");
  c_random_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
    addr_load ##[1:1000] (tx_load && state_r == sec_pkg::ST_DEV_ACK));
  c_seq_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
    tx_load && state_r == sec_pkg::ST_RDATA_ACK);
  c_cr_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
    scl_fall && state_r == sec_pkg::ST_RDATA_ACK && cr_rd_r);
  c_wdog_fire: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $fell(wdo_n_r));
endmodule : sec_ctrl

/* src/sec_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants and types of the serial EEPROM read and control block.
// Assumes: A 20 MHz system clock samples the two-wire bus pins.
// Notes:   Cycle counts are derived from the printed times and the clock rate.
//////////////////////////////////////////////////////////////////////////////
package sec_pkg;
  localparam int          ADDR_W       = 15;
  localparam int          PAGE_W       = 6;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [15:0] CR_WORD_ADDR = 16'hffff;
  localparam logic [3:0]  DEV_TYPE     = 4'ha;
  // Control byte field positions.
  localparam int          CR_HW_PROTECT_ENABLE_BIT      = 7;
  localparam int          CR_WD1       = 6;
  localparam int          CR_WD0       = 5;
  localparam int          CR_BP1       = 4;
  localparam int          CR_BP0       = 3;
  localparam int          CR_REGISTER_WRITE_LATCH      = 2;
  localparam int          CR_WEL       = 1;
  localparam int          CR_PUP       = 0;
  localparam logic [7:0]  CR_RESET     = 8'h60;
  localparam logic [7:0]  CR_CLR_WEL   = 8'h00;
  localparam logic [7:0]  CR_SET_WEL   = 8'h02;
  localparam logic [7:0]  CR_SET_REGISTER_WRITE_LATCH  = 8'h06;
  // Watchdog period codes and block protect bases.
  localparam logic [1:0]  WD_LONG      = 2'h0;
  localparam logic [1:0]  WD_MID       = 2'h1;
  localparam logic [1:0]  WD_SHORT     = 2'h2;
  localparam logic [1:0]  BP_NONE      = 2'h0;
  localparam logic [1:0]  BP_QUARTER   = 2'h1;
  localparam logic [1:0]  BP_HALF      = 2'h2;
  localparam logic [14:0] BP_Q_BASE    = 15'h6000;
  localparam logic [14:0] BP_H_BASE    = 15'h4000;
  // Timing.
  localparam longint      CLK_HZ       = 20000000;
  localparam longint      WD_LONG_MS   = 800;
  localparam longint      WD_MID_MS    = 400;
  localparam longint      WD_SHORT_MS  = 150;
  localparam longint      WD_LONG_CYC  = WD_LONG_MS * CLK_HZ / 1000;
  localparam longint      WD_MID_CYC   = WD_MID_MS * CLK_HZ / 1000;
  localparam longint      WD_SHORT_CYC = WD_SHORT_MS * CLK_HZ / 1000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEVADDR, ST_DEV_ACK, ST_ADDR1, ST_ADDR1_ACK, ST_ADDR0,
    ST_ADDR0_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } sec_state_e;
endpackage : sec_pkg

/* tb/sec_mst.sv */
// Purpose: Two-wire bus master model that drives the EEPROM block.
// Assumes: SDA has a pull-up and SCL rests high between frames.
// Notes:   Each byte result toggles res_stb_out.
`timescale 1ns/1ps
module sec_mst (
  output logic       scl_out = 1'b1,
  output logic       sda_low_out = 1'b0,
  input  wire logic  sda_in,
  output logic       res_stb_out = 1'b0,
  output logic [7:0] res_out
);
  int         hp = 200;
  logic       r;
  logic [7:0] exp_q[$];
  task automatic bitx(input logic b);
    #(hp/2) sda_low_out = !b;
    #(hp/2) scl_out = 1'b1;
    #(hp) r = sda_in;
    scl_out = 1'b0;
  endtask : bitx
  // Start when st is set, otherwise stop; the longer low phase lets the slave release first.
  task automatic cond(input logic st);
    #(hp/2) sda_low_out = !st;
    #(hp) scl_out = 1'b1;
    #(hp/2) sda_low_out = st;
    if (st) #(hp/2) scl_out = 1'b0;
  endtask : cond
  task automatic xb(input logic [7:0] b, input logic rd, input logic ack, input logic [7:0] e);
    exp_q.push_back(e);
    for (int i = 7; i >= 0; i--) begin
      bitx(rd | b[i]);
      res_out[i] = r;
    end
    bitx(rd ? !ack : 1'b1);
    if (!rd) res_out = {7'h0, !r};
    res_stb_out = !res_stb_out;
  endtask : xb
  task automatic tx(input logic sa, input logic [15:0] a, input int nw, input logic [7:0] w, input logic k,
                    input int nr, input logic [7:0] e0, input logic [7:0] e1);
    cond(1'b1);
    if (sa) begin
      xb({sec_pkg::DEV_TYPE, 4'h2}, 1'b0, 1'b0, 8'h01);
      xb(a[15:8], 1'b0, 1'b0, 8'h01);
      xb(a[7:0], 1'b0, 1'b0, 8'h01);
    end
    for (int i = 0; i < nw; i++) xb(w, 1'b0, 1'b0, {7'h0, k && i == 0});
    if (sa && nr > 0) cond(1'b1);
    if (nr > 0) xb({sec_pkg::DEV_TYPE, 4'h3}, 1'b0, 1'b0, 8'h01);
    if (nr > 0) xb(8'h00, 1'b1, nr > 1, e0);
    if (nr > 1) xb(8'h00, 1'b1, 1'b0, e1);
    cond(1'b0);
    $display("test at %h done", a);
  endtask : tx
endmodule : sec_mst

/* tb/sec_ctrl_bench.sv */
// Purpose: Self-checking bench of the EEPROM read and control block.
// Assumes: Watchdog periods cut to 200, 100 and 50 clocks.
// Notes:   Bus results are checked in order.
`timescale 1ns/1ps
module sec_ctrl_bench;
  logic       clk = 1'b0, rstn = 1'b0, batt = 1'b0, wp = 1'b0;
  logic [7:0] d0, d1;
  int         seed = 89607, fail_count = 0, total_checks = 0;
  wire        scl, m_low, stb, oe_n, sdo, wdo_n, powerup_reset_time_sel;
  wire        sda = !(m_low || (!oe_n && !sdo));
  always #25 clk = ~clk;
  sec_ctrl #(.WD_LONG_CYC(200), .WD_MID_CYC(100), .WD_SHORT_CYC(50)) u_sec_ctrl (.sys_clk_in(clk), .rstn_in(rstn),
    .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe_n_out(oe_n), .dev_sel_in(2'h1), .wp_pin_in(wp),
    .on_battery_in(batt), .wdog_timeout_n_out(wdo_n), .powerup_reset_time_sel_out(powerup_reset_time_sel));
  sec_mst u_sec_mst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda), .res_stb_out(stb), .res_out());
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(stb) if (u_sec_mst.exp_q.size() > 0)
    check("bus", u_sec_mst.res_out, u_sec_mst.exp_q.pop_front());
  initial #2000000 begin
    fail_count++;
    final_report();
  end
  initial begin
    #250 rstn = 1'b1;
    #200 {d0, d1} = 16'($random(seed));
    u_sec_mst.tx(1, 16'hffff, 0, 0, 0, 1, sec_pkg::CR_RESET, 0);
    u_sec_mst.tx(1, 16'h0000, 1, d1, 0, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 1, sec_pkg::CR_SET_WEL, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 0, 0, 0, 1, 8'h62, 0);
    u_sec_mst.tx(1, 16'h7fff, 1, d0, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'h0000, 1, d1, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'h7fff, 0, 0, 0, 2, d0, d1);
    u_sec_mst.tx(1, 16'h7fff, 0, 0, 0, 0, 0, 0);
    u_sec_mst.tx(0, 16'h7fff, 0, 0, 0, 1, d0, 0);
    u_sec_mst.tx(1, 16'hffff, 2, sec_pkg::CR_SET_REGISTER_WRITE_LATCH, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 1, 8'h03, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 0, 0, 0, 1, 8'h03, 0);
    check("pup", {7'h0, powerup_reset_time_sel}, 8'h01);
    batt = 1'b1;
    repeat (400) @(negedge clk);
    check("wdog", {7'h0, wdo_n}, 8'h01);
    batt = 1'b0;
    repeat (250) @(negedge clk);
    check("wdog", {7'h0, wdo_n}, 8'h00);
    u_sec_mst.tx(0, 16'h0000, 0, 0, 0, 1, d1, 0);
    check("wdog", {7'h0, wdo_n}, 8'h01);
    u_sec_mst.tx(1, 16'hffff, 1, sec_pkg::CR_SET_REGISTER_WRITE_LATCH, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 1, 8'hca, 1, 0, 0, 0);
    wp = 1'b1;
    u_sec_mst.tx(1, 16'hffff, 1, sec_pkg::CR_SET_REGISTER_WRITE_LATCH, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 1, sec_pkg::CR_SET_WEL, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'hffff, 0, 0, 0, 1, 8'hca, 0);
    u_sec_mst.tx(1, 16'h7fff, 1, ~d0, 1, 0, 0, 0);
    u_sec_mst.tx(1, 16'h7fff, 0, 0, 0, 1, d0, 0);
    check("wdog", {7'h0, wdo_n}, 8'h00);
    final_report();
  end
endmodule : sec_ctrl_bench
